// ### hdl/sss_pkg.sv
/*
   Shared constants and types for the scan sequencer with statistics.
   Assumes a 100 MHz clock and 32-bit Avalon-MM byte addressing.
*/
package sss_pkg;
   localparam int NCH = 8;
   localparam int CH_W = 3;
   localparam int VAL_W = 24;
   localparam int TS_W = 32;
   localparam int SUM_W = 56;
   localparam int CNT_W = 32;
   localparam int DLY_W = 16;
   localparam int IVL_W = 29;
   localparam int MEM_DEPTH = 50_000;
   localparam int PTR_W = 16;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1_000_000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam logic [IVL_W-1:0] MAX_INTERVAL_MS = 29'h1575_2618;
   localparam logic [DLY_W-1:0] MAX_DELAY_MS = 16'hEA60;
   localparam logic [15:0] MAX_SWEEPS = 16'hC350;
   localparam logic [15:0] MIN_SWEEPS = 16'h0001;
   localparam logic [PTR_W-1:0] MEM_LAST = 16'hC34F;
   localparam logic [PTR_W-1:0] MEM_FULL = 16'hC350;
   localparam logic [31:0] UNLIM_CODE = 32'h7F14_F5D2;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_IVL = 8'h08;
   localparam logic [7:0] OFF_COUNT = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_LIST = 8'h14;
   localparam logic [7:0] OFF_CHSEL = 8'h18;
   localparam logic [7:0] OFF_DELAY = 8'h1C;
   localparam logic [7:0] OFF_CHCFG = 8'h20;
   localparam logic [7:0] OFF_SMIN = 8'h24;
   localparam logic [7:0] OFF_SMAX = 8'h28;
   localparam logic [7:0] OFF_SAVG = 8'h2C;
   localparam logic [7:0] OFF_SCNT = 8'h30;
   localparam logic [7:0] OFF_TMIN = 8'h34;
   localparam logic [7:0] OFF_TMAX = 8'h38;
   localparam logic [7:0] OFF_MIDX = 8'h3C;
   localparam logic [7:0] OFF_MVAL = 8'h40;
   localparam logic [7:0] OFF_MINFO = 8'h44;
   localparam logic [7:0] OFF_MTS = 8'h48;
   localparam logic [7:0] OFF_POINTS = 8'h4C;
   localparam logic [7:0] OFF_ABST = 8'h50;
   // command and mode bit positions
   localparam int CB_ARM = 0;
   localparam int CB_CANCEL = 1;
   localparam int CB_TRIG = 2;
   localparam int CB_SCLR = 3;
   localparam int CB_RST = 4;
   localparam int CB_PRESET = 5;
   localparam int MB_STREAM = 0;
   localparam int MB_ALM = 1;
   localparam int MB_CHN = 2;
   localparam int MB_TIME = 3;
   localparam int MB_UNIT = 4;
   localparam int MB_ABS = 5;
   localparam int COUNT_UNLIM_BIT = 16;
   localparam logic [5:0] MODE_RST = 6'h00;
   localparam logic [15:0] COUNT_RST = 16'h0001;
   localparam logic [IVL_W-1:0] IVL_RST = 29'h0000_0000;
   // automatic settling delay parts, in ms
   localparam logic [DLY_W-1:0] AUTO_BASE_MS [4] = '{16'h0002, 16'h0002, 16'h0064, 16'h000A};
   localparam logic [DLY_W-1:0] AUTO_INTEG_MS = 16'h0002;
   localparam logic [DLY_W-1:0] AUTO_RANGE_MS = 16'h0005;
   localparam logic [DLY_W-1:0] AUTO_FILT_MS = 16'h01F4;

   typedef enum logic [1:0] {ALM_NONE = 2'h0, ALM_LO = 2'h1, ALM_HI = 2'h2} sss_alarm_t;
   typedef enum logic [6:0] {
      S_IDLE = 7'h01, S_ARMED = 7'h02, S_SEL = 7'h04, S_SETTLE = 7'h08,
      S_MEAS = 7'h10, S_OUT = 7'h20, S_WAIT = 7'h40
   } sss_state_t;
   typedef struct packed {
      logic [TS_W-1:0] ts;
      logic [CH_W-1:0] chan;
      sss_alarm_t alarm;
      logic [3:0] unit;
      logic [VAL_W-1:0] value;
   } sss_rdg_t;
endpackage

// ### hdl/sss_timebase.sv
/*
   Millisecond timebase: one tick pulse, relative and absolute ms counters.
   Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module sss_timebase #(
   parameter int TICK_CYCLES = sss_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rel_clr,
   input wire logic abs_load,
   input wire logic [31:0] abs_val,
   output logic tick,
   output logic [31:0] rel_ms,
   output logic [31:0] abs_ms
);
   localparam int PW = $clog2(TICK_CYCLES + 1);
   logic [PW-1:0] pre_reg;
   wire pre_end = (pre_reg == PW'(TICK_CYCLES - 1));

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pre_reg <= '0;
         tick <= 1'b0;
      end
      else
      begin
         pre_reg <= pre_end ? '0 : pre_reg + 1'b1;
         tick <= pre_end;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n || rel_clr)
         rel_ms <= '0;
      else if (tick)
         rel_ms <= rel_ms + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         abs_ms <= '0;
      else if (abs_load)
         abs_ms <= abs_val;
      else if (tick)
         abs_ms <= abs_ms + 1'b1;
   end
endmodule

// ### hdl/sss_scan_seq.sv
/*
   Scan sequencer: sweep pacing, settling, store or stream, statistics.
   Assumes an Avalon-MM master, a measurement engine and a stream sink
   on the same clock.
*/
`timescale 1ns/1ns
// Functional notes
// - sweep start interval 0..359999 s, ms steps
// - run programmed sweep count, then stop
// - unlimited count reads back special code
// - wait settling delay before each measurement
// - per-channel delay 0..60 s, ms steps
// - writing delay clears automatic flag
// - automatic delay from channel settings
// - cancel stops scan in progress
// - arm waits; scan starts on trigger
// - store mode: wrapping 50000-entry memory
// - stream mode pauses while sink full
// - software trigger command starts scan
// - reading holds units, time, channel, alarm
// - alarm code 0 none, 1 low, 2 high
// - one format for all scan readings
// - four field flags, all default off
// - absolute or relative stamps, relative default
// - per-channel min, max, average during scan
// - statistics cleared on start, clear, reset, preset
// - no readings yet reads zero
// - extreme reading time kept as absolute
// - statistics only for scan-list channels
// - cancel finishes measurement, never resumes
// - ascending order, listed channels only
module sss_scan_seq #(
   parameter int TICK_CYCLES = sss_pkg::TICK_CYCLES
) (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic [2:0] RELAY_CH,
   output logic RELAY_CLOSE,
   output logic MEAS_START,
   input wire logic MEAS_DONE,
   input wire logic [23:0] MEAS_VALUE,
   input wire logic [3:0] MEAS_UNIT,
   input wire logic MEAS_ALM_LO,
   input wire logic MEAS_ALM_HI,
   output logic STREAM_VALID,
   output sss_pkg::sss_rdg_t STREAM_DATA,
   input wire logic STREAM_READY,
   output logic SCAN_BUSY
);
   localparam int NCH = sss_pkg::NCH;
   localparam int CH_W = sss_pkg::CH_W;
   localparam int VAL_W = sss_pkg::VAL_W;
   localparam int SUM_W = sss_pkg::SUM_W;
   localparam int DLY_W = sss_pkg::DLY_W;

   function automatic logic [DLY_W-1:0] auto_delay(input logic [6:0] c);
      logic [DLY_W-1:0] d;
      d = sss_pkg::AUTO_BASE_MS[c[1:0]];
      d = d + DLY_W'(c[5:4]) * sss_pkg::AUTO_INTEG_MS;
      if (c[3:2] == 2'h0)
         d = d + sss_pkg::AUTO_RANGE_MS;
      if (c[6])
         d = d + sss_pkg::AUTO_FILT_MS;
      return d;
   endfunction

   function automatic sss_pkg::sss_rdg_t fmt(input sss_pkg::sss_rdg_t r, input logic [5:0] m);
      sss_pkg::sss_rdg_t f;
      f = r;
      if (!m[sss_pkg::MB_ALM])
         f.alarm = sss_pkg::ALM_NONE;
      if (!m[sss_pkg::MB_CHN])
         f.chan = '0;
      if (!m[sss_pkg::MB_TIME])
         f.ts = '0;
      if (!m[sss_pkg::MB_UNIT])
         f.unit = '0;
      return f;
   endfunction

   sss_pkg::sss_state_t state_reg, state_next;
   logic ack_reg;
   logic [31:0] rdata_reg, rd_word;
   logic [5:0] mode_reg;
   logic [sss_pkg::IVL_W-1:0] ivl_reg, since_reg;
   logic [15:0] count_reg, sweeps_reg;
   logic unlim_reg, cancel_reg, mstart_reg;
   logic [NCH-1:0] list_reg;
   logic [CH_W-1:0] chsel_reg, ch_reg;
   logic [DLY_W-1:0] cnt_reg;
   logic [sss_pkg::PTR_W-1:0] midx_reg, wptr_reg, points_reg;
   logic wrap_reg;
   sss_pkg::sss_rdg_t stream_reg;
   sss_pkg::sss_rdg_t mem [sss_pkg::MEM_DEPTH];
   logic [DLY_W-1:0] dly_reg [NCH];
   logic auto_reg [NCH];
   logic [6:0] cfg_reg [NCH];
   logic signed [VAL_W-1:0] smin_reg [NCH];
   logic signed [VAL_W-1:0] smax_reg [NCH];
   logic signed [SUM_W-1:0] ssum_reg [NCH];
   logic [sss_pkg::CNT_W-1:0] scnt_reg [NCH];
   logic [31:0] tmin_reg [NCH];
   logic [31:0] tmax_reg [NCH];
   logic tick;
   logic [31:0] rel_ms, abs_ms;

   // bus decode
   wire req = AVS_READ | AVS_WRITE;
   wire [7:0] addr = {AVS_ADDRESS[7:2], 2'b00};
   wire wr = AVS_WRITE & ack_reg & (AVS_BYTEENABLE == 4'hF);
   wire [31:0] wd = AVS_WRITEDATA;
   wire wr_ctrl = wr && (addr == sss_pkg::OFF_CTRL);
   wire wr_delay = wr && (addr == sss_pkg::OFF_DELAY);
   wire wr_chcfg = wr && (addr == sss_pkg::OFF_CHCFG);
   wire cmd_arm = wr_ctrl & wd[sss_pkg::CB_ARM];
   wire cmd_cancel = wr_ctrl & wd[sss_pkg::CB_CANCEL];
   wire cmd_trig = wr_ctrl & wd[sss_pkg::CB_TRIG];
   wire cmd_sclr = wr_ctrl & (wd[sss_pkg::CB_SCLR] | wd[sss_pkg::CB_RST] | wd[sss_pkg::CB_PRESET]);

   // sequencing decode
   wire stream = mode_reg[sss_pkg::MB_STREAM];
   wire ch_in = list_reg[ch_reg];
   wire ch_last = (ch_reg == CH_W'(NCH - 1));
   wire cancel_hit = cancel_reg | cmd_cancel;
   wire sweep_final = !unlim_reg && ({1'b0, sweeps_reg} + 17'h0_0001 >= {1'b0, count_reg});
   wire meas_done = (state_reg == sss_pkg::S_MEAS) && MEAS_DONE;
   wire adv = (meas_done && !stream) || (state_reg == sss_pkg::S_OUT && STREAM_READY);
   wire scan_start = (state_reg == sss_pkg::S_ARMED) && cmd_trig && !cmd_cancel;
   wire sweep_go = scan_start || (state_reg == sss_pkg::S_WAIT && state_next == sss_pkg::S_SEL);
   wire sel_skip_end = (state_reg == sss_pkg::S_SEL) && !ch_in && ch_last && !cmd_cancel;
   wire sweep_end = sel_skip_end || (adv && ch_last && !cancel_hit);
   wire ch_inc = (state_next == sss_pkg::S_SEL) && !sweep_go;
   wire stats_clr = cmd_sclr || scan_start;
   wire [DLY_W-1:0] sel_dly = auto_reg[ch_reg] ? auto_delay(cfg_reg[ch_reg]) : dly_reg[ch_reg];
   wire [DLY_W-1:0] rd_dly = auto_reg[chsel_reg] ? auto_delay(cfg_reg[chsel_reg]) : dly_reg[chsel_reg];
   wire sel_ok = list_reg[chsel_reg] && (scnt_reg[chsel_reg] != '0);
   wire signed [SUM_W-1:0] avg_w = sel_ok ?
      ssum_reg[chsel_reg] / $signed({1'b0, scnt_reg[chsel_reg]}) : '0;
   sss_pkg::sss_alarm_t alm_w;
   sss_pkg::sss_rdg_t new_rdg, mem_rd;
   assign alm_w = MEAS_ALM_HI ? sss_pkg::ALM_HI : (MEAS_ALM_LO ? sss_pkg::ALM_LO : sss_pkg::ALM_NONE);
   assign new_rdg.ts = mode_reg[sss_pkg::MB_ABS] ? abs_ms : rel_ms;
   assign new_rdg.chan = ch_reg;
   assign new_rdg.alarm = alm_w;
   assign new_rdg.unit = MEAS_UNIT;
   assign new_rdg.value = MEAS_VALUE;
   assign mem_rd = (midx_reg < sss_pkg::MEM_FULL) ? fmt(mem[midx_reg], mode_reg) : '0;

   sss_timebase #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tb (
      .clk(MCLK),
      .rst_n(RESETN),
      .rel_clr(scan_start),
      .abs_load(wr && (addr == sss_pkg::OFF_ABST)),
      .abs_val(wd),
      .tick(tick),
      .rel_ms(rel_ms),
      .abs_ms(abs_ms)
   );

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         sss_pkg::S_IDLE:
            if (cmd_arm)
               state_next = sss_pkg::S_ARMED;
         sss_pkg::S_ARMED:
            if (cmd_cancel)
               state_next = sss_pkg::S_IDLE;
            else if (cmd_trig)
               state_next = sss_pkg::S_SEL;
         sss_pkg::S_SEL:
            if (cmd_cancel)
               state_next = sss_pkg::S_IDLE;
            else if (ch_in)
               state_next = sss_pkg::S_SETTLE;
            else if (ch_last)
               state_next = sweep_final ? sss_pkg::S_IDLE : sss_pkg::S_WAIT;
         sss_pkg::S_SETTLE:
            if (cmd_cancel)
               state_next = sss_pkg::S_IDLE;
            else if (cnt_reg == '0)
               state_next = sss_pkg::S_MEAS;
         sss_pkg::S_MEAS, sss_pkg::S_OUT:
            if (meas_done && stream)
               state_next = sss_pkg::S_OUT;
            else if (adv)
            begin
               if (cancel_hit)
                  state_next = sss_pkg::S_IDLE;
               else if (!ch_last)
                  state_next = sss_pkg::S_SEL;
               else
                  state_next = sweep_final ? sss_pkg::S_IDLE : sss_pkg::S_WAIT;
            end
         sss_pkg::S_WAIT:
            if (cmd_cancel)
               state_next = sss_pkg::S_IDLE;
            else if (since_reg >= ivl_reg)
               state_next = sss_pkg::S_SEL;
         default:
            state_next = sss_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESETN)
         state_reg <= sss_pkg::S_IDLE;
      else
         state_reg <= state_next;
   end

   // sweep position and counters
   always_ff @(posedge MCLK)
   begin
      if (!RESETN || sweep_go)
         ch_reg <= '0;
      else if (ch_inc)
         ch_reg <= ch_reg + 1'b1;
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESETN)
         cnt_reg <= '0;
      else if (state_reg == sss_pkg::S_SEL && ch_in)
         cnt_reg <= sel_dly;
      else if (state_reg == sss_pkg::S_SETTLE && tick && cnt_reg != '0)
         cnt_reg <= cnt_reg - 1'b1;
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESETN || sweep_go)
         since_reg <= '0;
      else if (tick && since_reg < ivl_reg)
         since_reg <= since_reg + 1'b1;
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESETN || scan_start)
         sweeps_reg <= '0;
      else if (sweep_end)
         sweeps_reg <= sweeps_reg + 1'b1;
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESETN || state_reg == sss_pkg::S_IDLE)
         cancel_reg <= 1'b0;
      else if (cmd_cancel)
         cancel_reg <= 1'b1;
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESETN)
      begin
         mstart_reg <= 1'b0;
         stream_reg <= '0;
      end
      else
      begin
         mstart_reg <= (state_reg == sss_pkg::S_SETTLE) && (state_next == sss_pkg::S_MEAS);
         if (meas_done)
            stream_reg <= fmt(new_rdg, mode_reg);
      end
   end

   // wrapping reading memory
   always_ff @(posedge MCLK)
   begin
      if (meas_done && !stream)
         mem[wptr_reg] <= new_rdg;
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESETN || scan_start)
      begin
         wptr_reg <= '0;
         points_reg <= '0;
         wrap_reg <= 1'b0;
      end
      else if (meas_done && !stream)
      begin
         wptr_reg <= (wptr_reg == sss_pkg::MEM_LAST) ? '0 : wptr_reg + 1'b1;
         if (points_reg != sss_pkg::MEM_FULL)
            points_reg <= points_reg + 1'b1;
         if (wptr_reg == sss_pkg::MEM_LAST)
            wrap_reg <= 1'b1;
      end
   end

   // per-channel settings and statistics
   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      wire sel_i = (chsel_reg == CH_W'(i));
      wire hit = meas_done && (ch_reg == CH_W'(i)) && list_reg[i];
      wire first = (scnt_reg[i] == '0);
      wire signed [VAL_W-1:0] v = MEAS_VALUE;
      wire signed [SUM_W-1:0] vx = {{(SUM_W - VAL_W){v[VAL_W-1]}}, v};

      always_ff @(posedge MCLK)
      begin
         if (!RESETN)
         begin
            dly_reg[i] <= '0;
            auto_reg[i] <= 1'b1;
            cfg_reg[i] <= '0;
         end
         else if (wr_delay && sel_i)
         begin
            dly_reg[i] <= (wd > 32'(sss_pkg::MAX_DELAY_MS)) ? sss_pkg::MAX_DELAY_MS : wd[DLY_W-1:0];
            auto_reg[i] <= 1'b0;
         end
         else if (wr_chcfg && sel_i)
         begin
            auto_reg[i] <= wd[0];
            cfg_reg[i] <= wd[7:1];
         end
      end

      always_ff @(posedge MCLK)
      begin
         if (!RESETN || stats_clr)
            scnt_reg[i] <= '0;
         else if (hit)
            scnt_reg[i] <= scnt_reg[i] + 1'b1;
      end

      always_ff @(posedge MCLK)
      begin
         if (!RESETN)
         begin
            smin_reg[i] <= '0;
            smax_reg[i] <= '0;
            ssum_reg[i] <= '0;
            tmin_reg[i] <= '0;
            tmax_reg[i] <= '0;
         end
         else if (hit)
         begin
            ssum_reg[i] <= (first ? '0 : ssum_reg[i]) + vx;
            if (first || v < smin_reg[i])
            begin
               smin_reg[i] <= v;
               tmin_reg[i] <= abs_ms;
            end
            if (first || v > smax_reg[i])
            begin
               smax_reg[i] <= v;
               tmax_reg[i] <= abs_ms;
            end
         end
      end
   end

   // software-written configuration
   always_ff @(posedge MCLK)
   begin
      if (!RESETN)
      begin
         mode_reg <= sss_pkg::MODE_RST;
         ivl_reg <= sss_pkg::IVL_RST;
         count_reg <= sss_pkg::COUNT_RST;
         unlim_reg <= 1'b0;
         list_reg <= '0;
         chsel_reg <= '0;
         midx_reg <= '0;
      end
      else if (wr)
      begin
         if (addr == sss_pkg::OFF_MODE)
            mode_reg <= wd[5:0];
         else if (addr == sss_pkg::OFF_IVL)
            ivl_reg <= (wd > 32'(sss_pkg::MAX_INTERVAL_MS)) ? sss_pkg::MAX_INTERVAL_MS : wd[28:0];
         else if (addr == sss_pkg::OFF_COUNT)
         begin
            unlim_reg <= wd[sss_pkg::COUNT_UNLIM_BIT];
            if (wd[15:0] < sss_pkg::MIN_SWEEPS)
               count_reg <= sss_pkg::MIN_SWEEPS;
            else if (wd[15:0] > sss_pkg::MAX_SWEEPS)
               count_reg <= sss_pkg::MAX_SWEEPS;
            else
               count_reg <= wd[15:0];
         end
         else if (addr == sss_pkg::OFF_LIST)
            list_reg <= wd[NCH-1:0];
         else if (addr == sss_pkg::OFF_CHSEL)
            chsel_reg <= wd[CH_W-1:0];
         else if (addr == sss_pkg::OFF_MIDX)
            midx_reg <= wd[15:0];
      end
   end

   // read mux
   always_comb
   begin
      rd_word = '0;
      if (addr == sss_pkg::OFF_MODE)
         rd_word = {26'h000_0000, mode_reg};
      else if (addr == sss_pkg::OFF_IVL)
         rd_word = {3'h0, ivl_reg};
      else if (addr == sss_pkg::OFF_COUNT)
         rd_word = unlim_reg ? sss_pkg::UNLIM_CODE : {16'h0000, count_reg};
      else if (addr == sss_pkg::OFF_STATUS)
         rd_word = {sweeps_reg, 11'h000, cancel_reg, wrap_reg, state_reg == sss_pkg::S_ARMED,
                    state_reg == sss_pkg::S_IDLE, SCAN_BUSY};
      else if (addr == sss_pkg::OFF_LIST)
         rd_word = {24'h00_0000, list_reg};
      else if (addr == sss_pkg::OFF_CHSEL)
         rd_word = {29'h0000_0000, chsel_reg};
      else if (addr == sss_pkg::OFF_DELAY)
         rd_word = {auto_reg[chsel_reg], 15'h0000, rd_dly};
      else if (addr == sss_pkg::OFF_CHCFG)
         rd_word = {24'h00_0000, cfg_reg[chsel_reg], auto_reg[chsel_reg]};
      else if (addr == sss_pkg::OFF_SMIN)
         rd_word = sel_ok ? 32'(smin_reg[chsel_reg]) : '0;
      else if (addr == sss_pkg::OFF_SMAX)
         rd_word = sel_ok ? 32'(smax_reg[chsel_reg]) : '0;
      else if (addr == sss_pkg::OFF_SAVG)
         rd_word = avg_w[31:0];
      else if (addr == sss_pkg::OFF_SCNT)
         rd_word = sel_ok ? scnt_reg[chsel_reg] : '0;
      else if (addr == sss_pkg::OFF_TMIN)
         rd_word = sel_ok ? tmin_reg[chsel_reg] : '0;
      else if (addr == sss_pkg::OFF_TMAX)
         rd_word = sel_ok ? tmax_reg[chsel_reg] : '0;
      else if (addr == sss_pkg::OFF_MIDX)
         rd_word = {16'h0000, midx_reg};
      else if (addr == sss_pkg::OFF_MVAL)
         rd_word = 32'($signed(mem_rd.value));
      else if (addr == sss_pkg::OFF_MINFO)
         rd_word = {23'h00_0000, mem_rd.chan, mem_rd.alarm, mem_rd.unit};
      else if (addr == sss_pkg::OFF_MTS)
         rd_word = mem_rd.ts;
      else if (addr == sss_pkg::OFF_POINTS)
         rd_word = {16'h0000, points_reg};
      else if (addr == sss_pkg::OFF_ABST)
         rd_word = abs_ms;
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESETN)
      begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end
      else
      begin
         ack_reg <= req & ~ack_reg;
         if (AVS_READ && !ack_reg)
            rdata_reg <= rd_word;
      end
   end

   assign AVS_WAITREQUEST = req & ~ack_reg;
   assign AVS_READDATA = rdata_reg;
   assign RELAY_CH = ch_reg;
   assign RELAY_CLOSE = (state_reg == sss_pkg::S_SETTLE) || (state_reg == sss_pkg::S_MEAS);
   assign MEAS_START = mstart_reg;
   assign STREAM_VALID = (state_reg == sss_pkg::S_OUT);
   assign STREAM_DATA = stream_reg;
   assign SCAN_BUSY = !(state_reg == sss_pkg::S_IDLE || state_reg == sss_pkg::S_ARMED);
endmodule

// ### sim/sss_scan_seq_props.sv
/* port checker for the scan sequencer
   bound to sss_scan_seq, one clock domain */
`timescale 1ns/1ns
module sss_scan_seq_props (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic AVS_WAITREQUEST,
   input wire logic [2:0] RELAY_CH,
   input wire logic RELAY_CLOSE,
   input wire logic MEAS_START,
   input wire logic MEAS_DONE,
   input wire logic STREAM_VALID,
   input wire sss_pkg::sss_rdg_t STREAM_DATA,
   input wire logic STREAM_READY,
   input wire logic SCAN_BUSY
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   sequence one_wait;
      AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
   endsequence
   sequence start_once;
      MEAS_START ##1 !MEAS_START;
   endsequence
   bus_answer_a: assert property ($rose(AVS_READ | AVS_WRITE) |-> one_wait)
      else $error("late bus answer");
   settle_first_a: assert property ($rose(RELAY_CLOSE) |-> !MEAS_START)
      else $error("no settle cycle");
   start_closed_a: assert property (MEAS_START |-> RELAY_CLOSE && $past(RELAY_CLOSE))
      else $error("start, relay open");
   start_pulse_a: assert property (MEAS_START |-> start_once)
      else $error("long start pulse");
   done_release_a: assert property (MEAS_DONE && RELAY_CLOSE && !MEAS_START |=> !RELAY_CLOSE)
      else $error("relay held");
   stream_hold_a: assert property (STREAM_VALID && !STREAM_READY |=> STREAM_VALID && $stable(STREAM_DATA))
      else $error("stall broken");
   idle_quiet_a: assert property (!SCAN_BUSY |-> !(RELAY_CLOSE || MEAS_START || STREAM_VALID))
      else $error("idle activity");
   chan_steady_a: assert property (RELAY_CLOSE && $past(RELAY_CLOSE) |-> $stable(RELAY_CH))
      else $error("channel moved");
   alarm_code_a: assert property (STREAM_VALID |-> STREAM_DATA.alarm != 2'h3)
      else $error("bad alarm");
endmodule
bind sss_scan_seq sss_scan_seq_props u_sss_scan_seq_props (.*);

// ### sim/sss_meas_model.sv
/* measurement engine model
   answers each start a few clocks later */
`timescale 1ns/1ns
module sss_meas_model (
   input wire logic MCLK,
   input wire logic MEAS_START,
   input wire logic [2:0] RELAY_CH,
   output logic MEAS_DONE,
   output logic [23:0] MEAS_VALUE,
   output logic [3:0] MEAS_UNIT,
   output logic MEAS_ALM_LO,
   output logic MEAS_ALM_HI
);
   logic [2:0] cnt_reg = 3'h0;
   assign MEAS_UNIT = 4'h3;
   always @(posedge MCLK)
   begin
      cnt_reg <= MEAS_START ? 3'h4 : cnt_reg - 3'(cnt_reg != 3'h0);
      MEAS_DONE <= (cnt_reg == 3'h1);
      MEAS_VALUE <= (cnt_reg == 3'h1) ? {21'h00_0020, RELAY_CH} : ~MEAS_VALUE;
      MEAS_ALM_LO <= (RELAY_CH == 3'h2);
      MEAS_ALM_HI <= (RELAY_CH == 3'h0);
   end
endmodule

// ### sim/sss_scan_seq_tb.sv
/* bench for sss_scan_seq
   assumes sss_meas_model on the far side */
`timescale 1ns/1ns
module sss_scan_seq_tb;
   localparam int TK = 10;
   logic MCLK = 1'b0, RESETN = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, STREAM_READY = 1'b0;
   logic [7:0] AVS_ADDRESS = 8'h00;
   logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
   logic [3:0] AVS_BYTEENABLE = 4'hF;
   logic [31:0] AVS_READDATA, q;
   logic [23:0] MEAS_VALUE;
   logic [3:0] MEAS_UNIT;
   logic [2:0] RELAY_CH;
   logic AVS_WAITREQUEST, RELAY_CLOSE, MEAS_START, MEAS_DONE, MEAS_ALM_LO, MEAS_ALM_HI, STREAM_VALID, SCAN_BUSY;
   sss_pkg::sss_rdg_t STREAM_DATA;
   int miscompares = 0, total_checks = 0, sc = 0, s2 = 0, nx = 0;
   logic [2:0] seq_q[$];
   always #5 MCLK = ~MCLK;
   sss_scan_seq #(.TICK_CYCLES(TK)) u_sss_scan_seq (.*);
   sss_meas_model u_sss_meas_model (.*);
   always @(posedge MCLK)
   begin
      sc = RELAY_CLOSE ? sc + 1 : 0;
      nx = nx + int'(STREAM_VALID && STREAM_READY);
      if (MEAS_START)
         seq_q.push_back(RELAY_CH);
      if (MEAS_START && RELAY_CH == 3'h2)
         s2 = sc;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_READ <= !w;
      AVS_WRITE <= w;
      @(posedge MCLK iff !AVS_WAITREQUEST);
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string w);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, e, w);
   endtask
   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic end_sim;
      if (miscompares == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic t_regs;
      logic [15:0] ad;
      ad = sss_pkg::AUTO_BASE_MS[0] + sss_pkg::AUTO_RANGE_MS + sss_pkg::AUTO_FILT_MS;
      rdc(sss_pkg::OFF_MODE, 32'h0000_0000, "mode");
      rdc(sss_pkg::OFF_SMIN, 32'h0000_0000, "min");
      wrr(sss_pkg::OFF_CHCFG, 32'h0000_0081);
      rdc(sss_pkg::OFF_DELAY, {16'h8000, ad}, "auto");
      wrr(sss_pkg::OFF_DELAY, 32'h0000_EA61);
      rdc(sss_pkg::OFF_DELAY, {16'h0000, sss_pkg::MAX_DELAY_MS}, "dly");
      wrr(sss_pkg::OFF_DELAY, 32'h0000_0000);
      wrr(sss_pkg::OFF_COUNT, 32'h0001_0000);
      rdc(sss_pkg::OFF_COUNT, sss_pkg::UNLIM_CODE, "unlim");
      wrr(sss_pkg::OFF_COUNT, 32'h0000_C351);
      rdc(sss_pkg::OFF_COUNT, {16'h0000, sss_pkg::MAX_SWEEPS}, "cnt");
      wrr(sss_pkg::OFF_IVL, 32'hFFFF_FFFF);
      rdc(sss_pkg::OFF_IVL, {3'h0, sss_pkg::MAX_INTERVAL_MS}, "ivl");
      wrr(sss_pkg::OFF_IVL, 32'h0000_0000);
      wrr(sss_pkg::OFF_CTRL, 32'h0000_0004);
      chk(SCAN_BUSY, 1'b0, "no arm");
      rdc(8'hFC, 32'h0000_0000, "unmapped");
   endtask
   task automatic t_store;
      wrr(sss_pkg::OFF_COUNT, 32'h0000_0002);
      wrr(sss_pkg::OFF_LIST, 32'h0000_0005);
      wrr(sss_pkg::OFF_CHSEL, 32'h0000_0002);
      wrr(sss_pkg::OFF_DELAY, 32'h0000_0003);
      wrr(sss_pkg::OFF_CTRL, 32'h0000_0001);
      wrr(sss_pkg::OFF_CTRL, 32'h0000_0004);
      @(posedge MCLK iff !SCAN_BUSY);
      chk(seq_q.size(), 32'h0000_0004, "chans");
      foreach (seq_q[i])
         chk(seq_q[i], i % 2 * 2, "order");
      chk(s2 >= 2 * TK, 32'h0000_0001, "settle");
      bus(1'b0, sss_pkg::OFF_STATUS, 32'h0000_0000);
      chk(q[31:16], 32'h0000_0002, "sweeps");
      rdc(sss_pkg::OFF_POINTS, 32'h0000_0004, "points");
      rdc(sss_pkg::OFF_SCNT, 32'h0000_0002, "scnt");
      rdc(sss_pkg::OFF_SMAX, 32'h0000_0102, "max");
      rdc(sss_pkg::OFF_SAVG, 32'h0000_0102, "avg");
      wrr(sss_pkg::OFF_MIDX, 32'h0000_0001);
      rdc(sss_pkg::OFF_MINFO, 32'h0000_0000, "fmt off");
      wrr(sss_pkg::OFF_MODE, 32'h0000_0016);
      rdc(sss_pkg::OFF_MINFO, 32'h0000_0093, "fmt on");
      wrr(sss_pkg::OFF_CHSEL, 32'h0000_0001);
      rdc(sss_pkg::OFF_SCNT, 32'h0000_0000, "unlisted");
   endtask
   task automatic t_stream;
      wrr(sss_pkg::OFF_MODE, 32'h0000_0003);
      wrr(sss_pkg::OFF_LIST, 32'h0000_0001);
      wrr(sss_pkg::OFF_COUNT, 32'h0001_0000);
      wrr(sss_pkg::OFF_CTRL, 32'h0000_0001);
      wrr(sss_pkg::OFF_CTRL, 32'h0000_0004);
      @(posedge MCLK iff STREAM_VALID);
      repeat (5) @(posedge MCLK);
      chk(STREAM_VALID, 1'b1, "stall");
      chk(STREAM_DATA[31:0], 32'h2000_0100, "data");
      wrr(sss_pkg::OFF_CTRL, 32'h0000_0002);
      STREAM_READY <= 1'b1;
      @(posedge MCLK iff !SCAN_BUSY);
      repeat (20) @(posedge MCLK);
      chk(nx, 32'h0000_0001, "one out");
      chk(SCAN_BUSY, 1'b0, "stopped");
      wrr(sss_pkg::OFF_CHSEL, 32'h0000_0000);
      rdc(sss_pkg::OFF_SCNT, 32'h0000_0001, "restart");
      wrr(sss_pkg::OFF_CTRL, 32'h0000_0008);
      rdc(sss_pkg::OFF_SCNT, 32'h0000_0000, "cleared");
   endtask
   initial
   begin
      repeat (20) @(posedge MCLK);
      RESETN <= 1'b1;
      @(posedge MCLK);
      t_regs;
      t_store;
      t_stream;
      end_sim;
   end
   initial
   begin
      #500000;
      miscompares++;
      end_sim;
   end
endmodule
